//--- inc/pwc_params.svh
// Constants of the periodic wake-up counter: offsets, fields, reset values.
// Assumes a 32-bit classic Wishbone slave with byte addresses.
`ifndef PWC_PARAMS_SVH
`define PWC_PARAMS_SVH

`define PWC_ADR_STATUS      4'h0
`define PWC_ADR_COUNT       4'h4
`define PWC_ADR_LIMIT       4'h8

`define PWC_FLAG_BIT        7
`define PWC_SRC_HI          6
`define PWC_SRC_LO          5
`define PWC_IRQ_EN_BIT      4
`define PWC_DIV_HI          3

`define PWC_SRC_LOW_POWER   2'h0
`define PWC_SRC_EXT         2'h1

`define PWC_SRC_RESET       2'h0
`define PWC_DIV_RESET       4'h0
`define PWC_LIMIT_RESET     8'h00
`define PWC_COUNT_RESET     8'h00

`endif

//--- inc/pwc_pkg.sv
// Types of the periodic wake-up counter.
// Assumes pwc_params.svh is included by the design file.
package pwc_pkg;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [3:0]  adr;
        logic [31:0] dat;
    } pwc_wb_req_t;

    typedef struct packed {
        logic [1:0]  sync_low;
        logic [1:0]  sync_ext;
        logic [1:0]  sync_irc;
        logic        src_prev;
        logic [17:0] presc;
        logic [7:0]  count;
        logic [7:0]  limit;
        logic [1:0]  src_sel;
        logic [3:0]  div_sel;
        logic        irq_en;
        logic        flag;
        logic        irq;
        logic        ack;
        logic [31:0] rdata;
    } pwc_state_t;

endpackage : pwc_pkg

//--- src/pwc_wakeup_counter.sv
// Periodic wake-up counter with a classic Wishbone register slave.
// Assumes source clocks are asynchronous and far slower than clk_i.
`timescale 1ns/10ps
`include "pwc_params.svh"

module pwc_wakeup_counter (
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire pwc_pkg::pwc_wb_req_t wb_req_i,
    output logic                      wb_ack_o,
    output logic [31:0]               wb_dat_o,
    input  wire logic                 low_power_osc_1khz_i,
    input  wire logic                 external_ref_clock_i,
    input  wire logic                 internal_ref_clock_32k_i,
    input  wire logic                 debug_active_i,
    input  wire logic                 deep_stop_mode_i,
    output logic                      irq_o
);

    pwc_pkg::pwc_state_t s;
    pwc_pkg::pwc_state_t next_s;

    logic        req;
    logic        wr;
    logic        sel_clk;
    logic        src_ok;
    logic        edge_seen;
    logic        tick;
    logic        match;
    logic [17:0] div_n;
    logic [7:0]  wbyte;

    // Prescale ratio; zero means off
    function automatic logic [17:0] pwc_div(input logic hi, input logic [3:0] code);
        logic [17:0] v;
        v = 18'h00000;
        if (!hi) begin
            unique case (code)
                4'h0: v = 18'h00000;
                4'h1: v = 18'h00008;
                4'h2: v = 18'h00020;
                4'h3: v = 18'h00040;
                4'h4: v = 18'h00080;
                4'h5: v = 18'h00100;
                4'h6: v = 18'h00200;
                4'h7: v = 18'h00400;
                4'h8: v = 18'h00001;
                4'h9: v = 18'h00002;
                4'ha: v = 18'h00004;
                4'hb: v = 18'h0000a;
                4'hc: v = 18'h00010;
                4'hd: v = 18'h00064;
                4'he: v = 18'h001f4;
                4'hf: v = 18'h003e8;
            endcase
        end else begin
            unique case (code)
                4'h0: v = 18'h00000;
                4'h1: v = 18'h00400;
                4'h2: v = 18'h00800;
                4'h3: v = 18'h01000;
                4'h4: v = 18'h02000;
                4'h5: v = 18'h04000;
                4'h6: v = 18'h08000;
                4'h7: v = 18'h10000;
                4'h8: v = 18'h003e8;
                4'h9: v = 18'h007d0;
                4'ha: v = 18'h01388;
                4'hb: v = 18'h02710;
                4'hc: v = 18'h04e20;
                4'hd: v = 18'h0c350;
                4'he: v = 18'h186a0;
                4'hf: v = 18'h30d40;
            endcase
        end
        return v;
    endfunction : pwc_div

    // Ratio table written a second way, for the checks only
    function automatic logic [17:0] pwc_ref_div(input logic hi, input logic [3:0] code);
        logic [17:0] r;
        r = 18'h00000;
        if (!hi) begin
            unique case (code)
                4'h0: r = 18'h00000;
                4'h1: r = 18'h00001 << 3;
                4'h2: r = 18'h00001 << 5;
                4'h3: r = 18'h00001 << 6;
                4'h4: r = 18'h00001 << 7;
                4'h5: r = 18'h00001 << 8;
                4'h6: r = 18'h00001 << 9;
                4'h7: r = 18'h00001 << 10;
                4'h8: r = 18'h00001;
                4'h9: r = 18'h00001 << 1;
                4'ha: r = 18'h00001 << 2;
                4'hb: r = 18'h0000a;
                4'hc: r = 18'h00001 << 4;
                4'hd: r = 18'h0000a * 18'h0000a;
                4'he: r = 18'h00005 * 18'h00064;
                4'hf: r = 18'h0000a * 18'h00064;
            endcase
        end else begin
            unique case (code)
                4'h0: r = 18'h00000;
                4'h1: r = 18'h00001 << 10;
                4'h2: r = 18'h00001 << 11;
                4'h3: r = 18'h00001 << 12;
                4'h4: r = 18'h00001 << 13;
                4'h5: r = 18'h00001 << 14;
                4'h6: r = 18'h00001 << 15;
                4'h7: r = 18'h00001 << 16;
                4'h8: r = 18'h003e8;
                4'h9: r = 18'h00002 * 18'h003e8;
                4'ha: r = 18'h00005 * 18'h003e8;
                4'hb: r = 18'h0000a * 18'h003e8;
                4'hc: r = 18'h00014 * 18'h003e8;
                4'hd: r = 18'h00032 * 18'h003e8;
                4'he: r = 18'h00064 * 18'h003e8;
                4'hf: r = 18'h000c8 * 18'h003e8;
            endcase
        end
        return r;
    endfunction : pwc_ref_div

    always_comb begin
        next_s = s;
        req    = wb_req_i.cyc && wb_req_i.stb && !s.ack;
        wr     = req && wb_req_i.we && wb_req_i.sel[0];
        wbyte  = wb_req_i.dat[7:0];
        // Two-flop synchronisers for the source clocks
        next_s.sync_low = {s.sync_low[0], low_power_osc_1khz_i};
        next_s.sync_ext = {s.sync_ext[0], external_ref_clock_i};
        next_s.sync_irc = {s.sync_irc[0], internal_ref_clock_32k_i};
        unique case (s.src_sel)
            `PWC_SRC_LOW_POWER: sel_clk = s.sync_low[1];
            `PWC_SRC_EXT: sel_clk = s.sync_ext[1];
            default:      sel_clk = s.sync_irc[1];
        endcase
        next_s.src_prev = sel_clk;
        // In deep stop only the low-power source keeps running
        src_ok    = !(deep_stop_mode_i && (s.src_sel != `PWC_SRC_LOW_POWER));
        // Debug suspends counting; the held values stay
        edge_seen = sel_clk && !s.src_prev && src_ok && !debug_active_i;
        div_n     = pwc_div(s.src_sel[0], s.div_sel);
        tick      = 1'b0;
        match     = 1'b0;
        if (edge_seen && (div_n != 18'h00000)) begin
            if (s.presc >= div_n - 18'h00001) begin
                next_s.presc = 18'h00000;
                tick         = 1'b1;
            end else begin
                next_s.presc = s.presc + 18'h00001;
            end
        end
        if (tick) begin
            if (s.count == s.limit) begin
                next_s.count = `PWC_COUNT_RESET;
                match        = 1'b1;
            end else begin
                next_s.count = s.count + 8'h01;
            end
        end
        // Bus slave: one wait state, ack for one cycle
        next_s.ack   = req;
        next_s.rdata = 32'h00000000;
        if (req && !wb_req_i.we) begin
            unique case (wb_req_i.adr)
                `PWC_ADR_STATUS: next_s.rdata[7:0] = {s.flag, s.src_sel, s.irq_en, s.div_sel};
                `PWC_ADR_COUNT:  next_s.rdata[7:0] = s.count;
                `PWC_ADR_LIMIT:  next_s.rdata[7:0] = s.limit;
                default:         next_s.rdata = 32'h00000000;
            endcase
        end
        if (wr) begin
            unique case (wb_req_i.adr)
                `PWC_ADR_STATUS: begin
                    if (wbyte[`PWC_FLAG_BIT]) begin
                        next_s.flag = 1'b0;
                    end
                    if ((wbyte[`PWC_SRC_HI:`PWC_SRC_LO] != s.src_sel) ||
                        (wbyte[`PWC_DIV_HI:0] != s.div_sel)) begin
                        next_s.presc = 18'h00000;
                        next_s.count = `PWC_COUNT_RESET;
                        // Masks a false edge from the newly chosen source
                        next_s.src_prev = 1'b1;
                    end
                    next_s.src_sel = wbyte[`PWC_SRC_HI:`PWC_SRC_LO];
                    next_s.irq_en  = wbyte[`PWC_IRQ_EN_BIT];
                    next_s.div_sel = wbyte[`PWC_DIV_HI:0];
                end
                `PWC_ADR_LIMIT: begin
                    next_s.limit = wbyte;
                    next_s.presc = 18'h00000;
                    next_s.count = `PWC_COUNT_RESET;
                end
                default: begin
                    next_s.limit = s.limit;
                end
            endcase
        end
        // A match in the clearing cycle still sets the flag
        if (match) begin
            next_s.flag = 1'b1;
        end
        next_s.irq = next_s.flag && next_s.irq_en;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s         <= '0;
            s.src_sel <= `PWC_SRC_RESET;
            s.div_sel <= `PWC_DIV_RESET;
            s.limit   <= `PWC_LIMIT_RESET;
            s.count   <= `PWC_COUNT_RESET;
        end else begin
            s <= next_s;
        end
    end

    assign wb_ack_o = s.ack;
    assign wb_dat_o = s.rdata;
    assign irq_o    = s.irq;

    default clocking dc @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_ack_single_cycle: assert property (s.ack |=> !s.ack)
        else $error("ack held longer than one cycle");
    a_ack_after_req: assert property (wb_req_i.cyc && wb_req_i.stb && !s.ack |=> s.ack)
        else $error("request not acknowledged next cycle");
    a_match_sets_flag: assert property (match |=> s.flag)
        else $error("match did not set flag");
    a_match_wraps_count: assert property (match && !wr |=> s.count == 8'h00)
        else $error("count did not wrap on match");
    a_limit_write_clears: assert property (wr && wb_req_i.adr == `PWC_ADR_LIMIT
                                           |=> s.count == 8'h00 && s.presc == 18'h00000)
        else $error("limit write did not clear counters");
    a_select_change_clears: assert property (wr && wb_req_i.adr == `PWC_ADR_STATUS
                                             && wbyte[`PWC_SRC_HI:`PWC_SRC_LO] != s.src_sel
                                             |=> s.count == 8'h00 && s.presc == 18'h00000)
        else $error("source change did not clear counters");
    a_debug_holds_count: assert property (debug_active_i && !wr |=> $stable(s.count) && $stable(s.presc))
        else $error("count moved during debug");
    a_off_holds_count: assert property (s.div_sel == 4'h0 && !wr |=> $stable(s.count))
        else $error("count moved with prescaler off");
    a_deep_stop_gates: assert property (deep_stop_mode_i && s.src_sel != `PWC_SRC_LOW_POWER && !wr
                                        |=> $stable(s.presc))
        else $error("fast source ran in deep stop");
    a_irq_needs_flag: assert property ($rose(s.irq) |-> s.flag && s.irq_en)
        else $error("interrupt without flag and enable");
    a_count_read_only: assert property (wr && wb_req_i.adr == `PWC_ADR_COUNT && !tick
                                        |=> $stable(s.count))
        else $error("count changed by a bus write");

    // Prescaler checks
    a_ratio_table: assert property (div_n == pwc_ref_div(s.src_sel[0], s.div_sel))
        else $error("prescale ratio differs from table");
    a_presc_in_range: assert property (div_n != 18'h00000 |-> s.presc < div_n)
        else $error("prescaler beyond ratio");
    a_presc_steps: assert property (edge_seen && div_n != 18'h00000 && !tick && !wr
                                    |=> s.presc == $past(s.presc) + 18'h00001)
        else $error("prescaler did not step");
    a_tick_clears_presc: assert property (tick && !wr |=> s.presc == 18'h00000)
        else $error("prescaler not cleared on tick");
    a_ratio_one_ticks: assert property (edge_seen && div_n == 18'h00001 |-> tick)
        else $error("ratio one missed a tick");
    a_no_edge_holds: assert property (!edge_seen && !wr |=> $stable(s.presc))
        else $error("prescaler moved without an edge");
    a_off_no_tick: assert property (s.div_sel == 4'h0 |-> !tick)
        else $error("tick with prescaler off");
    a_debug_no_tick: assert property (debug_active_i |-> !tick)
        else $error("tick during debug");
    a_deep_stop_quiet: assert property (deep_stop_mode_i && s.src_sel != `PWC_SRC_LOW_POWER |-> !tick)
        else $error("tick from fast source in deep stop");
    a_low_power_runs: assert property (s.src_sel == `PWC_SRC_LOW_POWER |-> src_ok)
        else $error("low-power source gated");
    a_sync_two_flops: assert property (s.sync_low[1] == $past(s.sync_low[0]))
        else $error("synchroniser skipped a stage");

    // Counter checks
    a_count_steps_one: assert property (tick && s.count != s.limit && !wr
                                        |=> s.count == $past(s.count) + 8'h01)
        else $error("count did not step by one");
    a_count_no_tick: assert property (!tick && !wr |=> $stable(s.count))
        else $error("count moved without a tick");
    a_count_within_limit: assert property (s.count <= s.limit)
        else $error("count above match limit");
    a_match_at_limit: assert property (match |-> tick && s.count == s.limit)
        else $error("match away from the limit");
    a_zero_limit_flags: assert property (tick && s.limit == 8'h00 |=> s.flag)
        else $error("zero limit tick left flag clear");

    // Register checks
    a_flag_write_one: assert property (wr && wb_req_i.adr == `PWC_ADR_STATUS && wbyte[`PWC_FLAG_BIT] && !match
                                       |=> !s.flag)
        else $error("flag not cleared by writing one");
    a_flag_write_zero: assert property (wr && wb_req_i.adr == `PWC_ADR_STATUS && !wbyte[`PWC_FLAG_BIT] && s.flag
                                        |=> s.flag)
        else $error("flag cleared by writing zero");
    a_flag_set_wins: assert property (match && wr && wb_req_i.adr == `PWC_ADR_STATUS |=> s.flag)
        else $error("clear beat a match");
    a_flag_holds: assert property (!match && !wr |=> $stable(s.flag))
        else $error("flag changed on its own");
    a_src_write: assert property (wr && wb_req_i.adr == `PWC_ADR_STATUS
                                  |=> s.src_sel == $past(wbyte[`PWC_SRC_HI:`PWC_SRC_LO]))
        else $error("source select not written");
    a_div_write: assert property (wr && wb_req_i.adr == `PWC_ADR_STATUS
                                  |=> s.div_sel == $past(wbyte[`PWC_DIV_HI:0]))
        else $error("divider select not written");
    a_div_change_clears: assert property (wr && wb_req_i.adr == `PWC_ADR_STATUS && wbyte[`PWC_DIV_HI:0] != s.div_sel
                                          |=> s.count == 8'h00 && s.presc == 18'h00000)
        else $error("divider change did not clear counters");
    a_same_select_keeps: assert property (wr && wb_req_i.adr == `PWC_ADR_STATUS && !tick
                                          && wbyte[`PWC_SRC_HI:`PWC_SRC_LO] == s.src_sel
                                          && wbyte[`PWC_DIV_HI:0] == s.div_sel |=> $stable(s.count))
        else $error("unchanged select cleared the count");
    a_enable_write: assert property (wr && wb_req_i.adr == `PWC_ADR_STATUS
                                     |=> s.irq_en == $past(wbyte[`PWC_IRQ_EN_BIT]))
        else $error("interrupt enable not written");
    a_limit_write_value: assert property (wr && wb_req_i.adr == `PWC_ADR_LIMIT |=> s.limit == $past(wbyte))
        else $error("match limit not written");
    a_limit_stable: assert property (!wr |=> $stable(s.limit))
        else $error("match limit changed without a write");
    a_unmapped_write_ignored: assert property (wr && wb_req_i.adr != `PWC_ADR_STATUS && wb_req_i.adr != `PWC_ADR_LIMIT
                                               |=> $stable(s.limit) && $stable(s.src_sel)
                                                   && $stable(s.div_sel) && $stable(s.irq_en))
        else $error("write to a read-only word took effect");

    // Interrupt and read data checks
    a_irq_follows_flag: assert property (irq_o == (s.flag && s.irq_en))
        else $error("interrupt differs from flag and enable");
    a_irq_clear: assert property (wr && wb_req_i.adr == `PWC_ADR_STATUS && wbyte[`PWC_FLAG_BIT] && !match
                                  |=> !irq_o)
        else $error("request not cleared with the flag");
    a_irq_enable_off: assert property (wr && wb_req_i.adr == `PWC_ADR_STATUS && !wbyte[`PWC_IRQ_EN_BIT]
                                       |=> !irq_o)
        else $error("request while disabled");
    a_read_count: assert property (req && !wb_req_i.we && wb_req_i.adr == `PWC_ADR_COUNT
                                   |=> wb_dat_o[7:0] == $past(s.count))
        else $error("count read wrong");
    a_read_limit: assert property (req && !wb_req_i.we && wb_req_i.adr == `PWC_ADR_LIMIT
                                   |=> wb_dat_o[7:0] == $past(s.limit))
        else $error("limit read wrong");
    a_dat_idle_zero: assert property (!s.ack |-> wb_dat_o == 32'h00000000)
        else $error("read data outside ack");
    a_write_dat_zero: assert property (req && wb_req_i.we |=> wb_dat_o == 32'h00000000)
        else $error("read data on a write");
    a_upper_bits_zero: assert property (wb_dat_o[31:8] == 24'h000000)
        else $error("upper read bits set");

    c_match_seen: cover property (match);
    c_irq_raised: cover property ($rose(s.irq));
    c_zero_limit_match: cover property (match && s.limit == 8'h00);
    c_flag_cleared: cover property ($fell(s.flag));
    c_debug_edge: cover property (sel_clk && !s.src_prev && debug_active_i);

endmodule : pwc_wakeup_counter

//--- tb/pwc_wakeup_counter_test.sv
// Self-checking bench for the periodic wake-up counter, register access by classic Wishbone.
// Assumes the design from src/ and the package and header from inc/; source clocks are driven slowly.
`timescale 1ns/10ps
`include "pwc_params.svh"

module pwc_wakeup_counter_test;
    logic                 clk_i = 1'b0;
    logic                 rst_i = 1'b1;
    pwc_pkg::pwc_wb_req_t req   = '0;
    logic                 ack;
    logic [31:0]          rdat;
    logic [2:0]           sclk  = 3'h0;
    logic                 dbg   = 1'b0;
    logic                 deep  = 1'b0;
    logic                 irq;
    int                   bad_count   = 0;
    int                   check_count = 0;

    always #12.5 clk_i = ~clk_i;

    pwc_wakeup_counter pwc_wakeup_counter_i (
        .clk_i                    (clk_i),
        .rst_i                    (rst_i),
        .wb_req_i                 (req),
        .wb_ack_o                 (ack),
        .wb_dat_o                 (rdat),
        .low_power_osc_1khz_i     (sclk[0]),
        .external_ref_clock_i     (sclk[1]),
        .internal_ref_clock_32k_i (sclk[2]),
        .debug_active_i           (dbg),
        .deep_stop_mode_i         (deep),
        .irq_o                    (irq)
    );

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One classic cycle; holds the request until ack is sampled high
    task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        req <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: 4'hf, adr: a, dat: {24'h0, d}};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) begin
            bad_count++;
            wrap_up();
        end else begin
            q = rdat;
            req <= '0;
        end
    endtask : wb

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        logic [31:0] q;
        wb(1'b0, a, 8'h00, q);
        chk(q, {24'h0, exp});
    endtask : rd

    // Edges on one source clock, each level held for several bus cycles
    task automatic pulse(input int k, input int n);
        repeat (n) begin
            @(posedge clk_i);
            sclk[k] <= 1'b1;
            repeat (4) @(posedge clk_i);
            sclk[k] <= 1'b0;
            repeat (4) @(posedge clk_i);
        end
        repeat (6) @(posedge clk_i);
    endtask : pulse

    task automatic irq_is(input logic exp);
        repeat (2) @(posedge clk_i);
        chk({31'h0, irq}, {31'h0, exp});
    endtask : irq_is

    initial begin
        repeat (20000) @(posedge clk_i);
        bad_count++;
        wrap_up();
    end

    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(`PWC_ADR_STATUS, 8'h00);
        rd(`PWC_ADR_COUNT, 8'h00);
        rd(`PWC_ADR_LIMIT, 8'h00);
        rd(4'hc, 8'h00);
        wr(`PWC_ADR_LIMIT, 8'h03);
        rd(`PWC_ADR_LIMIT, 8'h03);
        wr(`PWC_ADR_COUNT, 8'h55);
        rd(`PWC_ADR_COUNT, 8'h00);
        // Ratio one, limit three: count wraps and raises the flag
        wr(`PWC_ADR_STATUS, 8'h08);
        pulse(0, 3);
        rd(`PWC_ADR_COUNT, 8'h03);
        rd(`PWC_ADR_STATUS, 8'h08);
        pulse(0, 1);
        rd(`PWC_ADR_COUNT, 8'h00);
        rd(`PWC_ADR_STATUS, 8'h88);
        irq_is(1'b0);
        wr(`PWC_ADR_STATUS, 8'h18);
        rd(`PWC_ADR_STATUS, 8'h98);
        irq_is(1'b1);
        wr(`PWC_ADR_STATUS, 8'h98);
        rd(`PWC_ADR_STATUS, 8'h18);
        irq_is(1'b0);
        // Limit write and divider change both clear the count
        pulse(0, 2);
        rd(`PWC_ADR_COUNT, 8'h02);
        wr(`PWC_ADR_LIMIT, 8'h03);
        rd(`PWC_ADR_COUNT, 8'h00);
        pulse(0, 2);
        wr(`PWC_ADR_STATUS, 8'h19);
        rd(`PWC_ADR_COUNT, 8'h00);
        pulse(0, 7);
        rd(`PWC_ADR_COUNT, 8'h03);
        pulse(0, 1);
        rd(`PWC_ADR_COUNT, 8'h00);
        rd(`PWC_ADR_STATUS, 8'h99);
        irq_is(1'b1);
        // Debug holds the count
        wr(`PWC_ADR_STATUS, 8'h08);
        pulse(0, 1);
        dbg <= 1'b1;
        pulse(0, 2);
        rd(`PWC_ADR_COUNT, 8'h01);
        dbg <= 1'b0;
        pulse(0, 1);
        rd(`PWC_ADR_COUNT, 8'h02);
        // Source selection and stop-mode gating
        wr(`PWC_ADR_STATUS, 8'h48);
        rd(`PWC_ADR_COUNT, 8'h00);
        pulse(0, 2);
        pulse(1, 1);
        rd(`PWC_ADR_COUNT, 8'h00);
        pulse(2, 2);
        rd(`PWC_ADR_COUNT, 8'h02);
        deep <= 1'b1;
        pulse(2, 1);
        rd(`PWC_ADR_COUNT, 8'h02);
        wr(`PWC_ADR_STATUS, 8'h08);
        rd(`PWC_ADR_COUNT, 8'h00);
        pulse(0, 2);
        rd(`PWC_ADR_COUNT, 8'h02);
        deep <= 1'b0;
        // Limit zero flags every tick
        wr(`PWC_ADR_LIMIT, 8'h00);
        wr(`PWC_ADR_STATUS, 8'h88);
        pulse(0, 1);
        rd(`PWC_ADR_STATUS, 8'h88);
        wr(`PWC_ADR_STATUS, 8'h88);
        rd(`PWC_ADR_STATUS, 8'h08);
        pulse(0, 1);
        rd(`PWC_ADR_STATUS, 8'h88);
        // External source, ratio 1000 from the high table
        wr(`PWC_ADR_LIMIT, 8'h05);
        wr(`PWC_ADR_STATUS, 8'h28);
        pulse(1, 999);
        rd(`PWC_ADR_COUNT, 8'h00);
        pulse(1, 1);
        rd(`PWC_ADR_COUNT, 8'h01);
        // Divider off stops all ticks
        wr(`PWC_ADR_STATUS, 8'h80);
        pulse(0, 3);
        rd(`PWC_ADR_COUNT, 8'h00);
        rd(`PWC_ADR_STATUS, 8'h00);
        wrap_up();
    end
endmodule : pwc_wakeup_counter_test
